// [parallel_memory_programming_port_tb.sv]
// Self-checking testbench for the parallel programming port
`timescale 1ns/100ps
`default_nettype none
module parallel_memory_programming_port_tb;
  import ppp_pkg::*;
  localparam int WC = 8;
  // Arbitrary identity values
  localparam logic [7:0] SIGS [3] = '{8'h31, 8'h62, 8'h93};
  localparam logic [7:0] CAL = 8'h9C;
  logic clk, nrst, en, ls, pl, wr_n, oe_n, ahi, alo, bs1, bs2, doe, rdy;
  logic [7:0] pdata, ddata, bus, lk, w;
  logic [7:0] ee [4];
  logic [7:0] fz [3];
  logic [15:0] fw [2];
  int err_count = 0;
  int checks_done = 0;
  int seed;
  // Wire level: device wins only while it drives
  assign bus = doe ? ddata : pdata;
  ppp_port #(.WRITE_CYC(WC), .SIG0(SIGS[0]), .SIG1(SIGS[1]),
    .SIG2(SIGS[2]), .CAL_BYTE(CAL)) ppp_port_inst (
    .clk_i(clk), .nrst_i(nrst), .en_i(en), .load_strobe_i(ls),
    .page_latch_strobe_i(pl), .write_strobe_n_i(wr_n),
    .output_enable_n_i(oe_n), .action_select_hi_i(ahi),
    .action_select_lo_i(alo), .byte_select_low_high_i(bs1),
    .byte_select_extended_i(bs2), .data_i(bus), .data_o(ddata),
    .data_oe_o(doe), .ready_busy_out_o(rdy));
  ppp_prog_model ppp_prog_model_inst (
    .clk_i(clk), .ready_i(rdy), .bus_i(bus), .load_o(ls), .latch_o(pl),
    .wr_n_o(wr_n), .oe_n_o(oe_n), .act_hi_o(ahi), .act_lo_o(alo),
    .bs_lh_o(bs1), .bs_ext_o(bs2), .data_o(pdata));
  // ****************************************************
  // Clock, verdict and watchdog
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run is some 9 us; over thirty times that means a hang
  initial begin
    #300_000;
    err_count++;
    complete_run();
  end
  // ****************************************************
  // Helpers and expectations
  // ****************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    ppp_prog_model_inst.load(PPP_ACT_CMD, 1'b0, b);
  endtask
  task automatic adr(input logic lh, input logic [7:0] b);
    ppp_prog_model_inst.load(PPP_ACT_ADDR, lh, b);
  endtask
  task automatic dat(input logic lh, input logic [7:0] b);
    ppp_prog_model_inst.load(PPP_ACT_DATA, lh, b);
  endtask
  task automatic rd(input logic ext, input logic lh, input logic [7:0] exp);
    logic [7:0] v;
    ppp_prog_model_inst.read(ext, lh, v);
    chk(v, exp);
  endtask
  task automatic wr(input logic lh, input logic ext, input int exp_busy);
    int b;
    ppp_prog_model_inst.write(lh, ext, b);
    chk(8'(b), 8'(exp_busy));
  endtask
  // Boot lock bits hold while both general locks are programmed
  function automatic logic [7:0] lock_next(input logic [7:0] cur,
                                           input logic [7:0] wv);
    logic [7:0] m;
    m = (cur[PPP_LOCK_GEN1_BIT] | cur[PPP_LOCK_GEN2_BIT]) ? 8'h00
        : PPP_BOOT_LOCK_MASK;
    return cur & (wv | m);
  endfunction
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    nrst = 1'b0;
    en = 1'b1;
    seed = $urandom(32'h8838);
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    chk({6'h00, rdy, doe}, 8'h02);
    // EEPROM page, refused first with the high select
    cmd(PPP_CMD_WR_EE);
    adr(1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ee[i] = 8'($urandom);
      adr(1'b0, 8'(8'h10 + i));
      dat(1'b0, ee[i]);
      ppp_prog_model_inst.latch();
    end
    wr(1'b1, 1'b0, 0);
    wr(1'b0, 1'b0, WC);
    cmd(PPP_CMD_RD_EE);
    for (int i = 0; i < 4; i++) begin
      adr(1'b0, 8'(8'h10 + i));
      rd(1'b0, 1'b0, ee[i]);
    end
    // Flash words, then no-operation blocks further writes
    cmd(PPP_CMD_WR_FLASH);
    for (int i = 0; i < 2; i++) begin
      fw[i] = 16'($urandom);
      adr(1'b0, 8'(8'h20 + i));
      dat(1'b0, fw[i][7:0]);
      dat(1'b1, fw[i][15:8]);
      ppp_prog_model_inst.latch();
    end
    cmd(PPP_CMD_NOP);
    wr(1'b0, 1'b0, 0);
    cmd(PPP_CMD_RD_FLASH);
    for (int i = 0; i < 2; i++) begin
      adr(1'b0, 8'(8'h20 + i));
      ppp_prog_model_inst.load(PPP_ACT_IDLE, 1'b0, 8'h20);
      rd(1'b0, 1'b0, fw[i][7:0]);
      rd(1'b0, 1'b1, fw[i][15:8]);
    end
    // Fuse bytes low, high, extended
    cmd(PPP_CMD_WR_FUSE);
    for (int k = 0; k < 3; k++) begin
      fz[k] = 8'($urandom);
      dat(1'b0, fz[k]);
      wr(k == 1, k == 2, WC);
    end
    cmd(PPP_CMD_RD_FUSE);
    rd(1'b0, 1'b0, fz[0]);
    rd(1'b1, 1'b1, fz[1]);
    rd(1'b1, 1'b0, fz[2]);
    rd(1'b0, 1'b1, PPP_LOCK_RST);
    // Locks: mode 3, refused boot locks, no clearing by writes
    lk = PPP_LOCK_RST;
    for (int j = 0; j < 3; j++) begin
      w = (j == 0) ? 8'hFC : (j == 1) ? (8'($urandom) & 8'hC3) : 8'hFF;
      cmd(PPP_CMD_WR_LOCK);
      dat(1'b0, w);
      wr(1'b0, 1'b0, WC);
      lk = lock_next(lk, w);
      cmd(PPP_CMD_RD_FUSE);
      rd(1'b0, 1'b1, lk);
    end
    cmd(PPP_CMD_ERASE);
    wr(1'b0, 1'b0, WC);
    cmd(PPP_CMD_RD_FUSE);
    rd(1'b0, 1'b1, PPP_LOCK_RST);
    // Signature and calibration bytes
    cmd(PPP_CMD_RD_SIG);
    for (int a = 0; a <= 2; a++) begin
      adr(1'b0, 8'(a));
      rd(1'b0, 1'b0, SIGS[a]);
    end
    adr(1'b0, PPP_CAL_ADDR);
    rd(1'b0, 1'b1, CAL);
    // Clock enable low: a whole load pulse goes unseen, command stays
    en = 1'b0;
    cmd(PPP_CMD_RD_FUSE);
    en = 1'b1;
    rd(1'b0, 1'b0, SIGS[0]);
    chk({7'h00, doe}, 8'h00);
    complete_run();
  end
endmodule // parallel_memory_programming_port_tb
`default_nettype wire

// [ppp_pkg.sv]
// Package for the parallel memory programming port
package ppp_pkg;
  // ****************************************************
  // Action select codes
  // ****************************************************
  localparam logic [1:0] PPP_ACT_ADDR = 2'b00;
  localparam logic [1:0] PPP_ACT_DATA = 2'b01;
  localparam logic [1:0] PPP_ACT_CMD = 2'b10;
  localparam logic [1:0] PPP_ACT_IDLE = 2'b11;
  // ****************************************************
  // Command bytes
  // ****************************************************
  localparam logic [7:0] PPP_CMD_NOP = 8'h00;
  localparam logic [7:0] PPP_CMD_ERASE = 8'h80;
  localparam logic [7:0] PPP_CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] PPP_CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] PPP_CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] PPP_CMD_WR_EE = 8'h11;
  localparam logic [7:0] PPP_CMD_RD_SIG = 8'h08;
  localparam logic [7:0] PPP_CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] PPP_CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] PPP_CMD_RD_EE = 8'h03;
  // ****************************************************
  // Reset values and field positions
  // ****************************************************
  localparam logic [7:0] PPP_ERASED = 8'hFF;
  localparam logic [7:0] PPP_LOCK_RST = 8'hFF;
  localparam logic [7:0] PPP_FUSE_RST = 8'hFF;
  // Idle pin levels: strobes low, write and enable high, action idle
  localparam logic [15:0] PPP_PIN_IDLE = 16'h3C00;
  localparam int PPP_LOCK_GEN1_BIT = 0;
  localparam int PPP_LOCK_GEN2_BIT = 1;
  localparam logic [7:0] PPP_BOOT_LOCK_MASK = 8'h3C;
  localparam logic [7:0] PPP_SIG_LAST = 8'h02;
  localparam logic [7:0] PPP_CAL_ADDR = 8'h00;
  // ****************************************************
  // Timing: self-timed write length
  // ****************************************************
  localparam int PPP_CLK_MHZ = 125;
  localparam int PPP_T_WRITE_US = 4;
  localparam int PPP_WRITE_CYC = PPP_T_WRITE_US * PPP_CLK_MHZ;
endpackage : ppp_pkg

// [ppp_port.sv]
// Parallel high-voltage programming port, device side
// Behaviour
// [RULE1] Action 10 with load strobe loads a command; 00h ends paging.
// [RULE2] EEPROM write data gathers in a page buffer, written as one page.
// [RULE3] Programmer loads 11h, address high, then low/data/page latch.
// [RULE4] Write strobe with byte select low programs page; busy low.
// [RULE5] Programmer waits for ready before the next page.
// [RULE6] Flash read, select 0: low byte of word driven.
// [RULE7] Flash read, select 1: high byte of word driven.
// [RULE8] EEPROM read drives addressed byte with select 0.
// [RULE9] Fuse low write via 40h and data byte; 0 programs.
// [RULE10] Select 1, extended 0 writes fuse high byte.
// [RULE11] Select 0, extended 1 writes extended fuse byte.
// [RULE12] Programmer returns raised select to 0 afterwards.
// [RULE13] Lock write via 20h and data byte; 0 programs a lock.
// [RULE14] Boot lock bits refused while both general locks programmed.
// [RULE15] Lock bits return to erased only by chip erase.
// [RULE16] Fuse/lock read: 00 low, 11 high, 10 extended, 01 lock.
// [RULE17] Signature read by address low 0..2 with select 0.
// [RULE18] Signature command, address 0, select 1: calibration byte.
// [RULE19] Action 00 loads address byte, 01 data, 11 nothing.
// [RULE20] Bus driven only while output enable low.
// [RULE21] Command and address kept across operations.
// [RULE22] Bytes captured on rising edge of load and page strobes.
`timescale 1ns/100ps
`default_nettype none
module ppp_port #(
  parameter int FLASH_WORDS = 256,
  parameter int EE_BYTES = 256,
  parameter int EE_PAGE = 4,
  parameter int WRITE_CYC = ppp_pkg::PPP_WRITE_CYC,
  parameter logic [7:0] SIG0 = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] SIG1 = 8'hA5, // Arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h3C, // Arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic load_strobe_i,
  input wire logic page_latch_strobe_i,
  input wire logic write_strobe_n_i,
  input wire logic output_enable_n_i,
  input wire logic action_select_hi_i,
  input wire logic action_select_lo_i,
  input wire logic byte_select_low_high_i,
  input wire logic byte_select_extended_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ready_busy_out_o
);
  import ppp_pkg::*;
  localparam int FW = $clog2(FLASH_WORDS);
  localparam int EW = $clog2(EE_BYTES);
  localparam int PW = $clog2(EE_PAGE);
  localparam int CW = $clog2(WRITE_CYC + 1);

  typedef enum logic [1:0] {PPP_IDLE, PPP_BUSY} ppp_state_e;

  // ****************************************************
  // Pin synchronisers: two flops, stage one read by stage two only
  // ****************************************************
  // Reset to idle pin levels so no false strobe edge follows reset
  logic [15:0] s1_q, s2_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= PPP_PIN_IDLE;
      s2_q <= PPP_PIN_IDLE;
    end else if (en_i) begin
      s1_q <= {load_strobe_i, page_latch_strobe_i, write_strobe_n_i,
               output_enable_n_i, action_select_hi_i, action_select_lo_i,
               byte_select_low_high_i, byte_select_extended_i, data_i};
      s2_q <= s1_q;
    end
  end
  logic ld, pl, wr_n, oe_n, bs1, bs2;
  logic [1:0] act;
  logic [7:0] din;
  assign {ld, pl, wr_n, oe_n, act, bs1, bs2, din} = s2_q;

  // Edge history for strobes
  logic ld_q, pl_q, wr_q;
  logic ld_rise, pl_rise, wr_fall;
  assign ld_rise = ld & ~ld_q; // RULE22
  assign pl_rise = pl & ~pl_q; // RULE22
  assign wr_fall = ~wr_n & wr_q;

  // ****************************************************
  // Storage arrays
  // ****************************************************
  logic [15:0] flash_q [FLASH_WORDS];
  logic [7:0] ee_q [EE_BYTES];
  logic [7:0] pbuf_q [EE_PAGE];
  logic [EE_PAGE-1:0] pvalid_q, pvalid_d;

  // ****************************************************
  // Control state next values
  // ****************************************************
  logic [7:0] cmd_q, cmd_d, alo_q, alo_d, ahi_q, ahi_d;
  logic [7:0] dlo_q, dlo_d, dhi_q, dhi_d;
  logic [7:0] fl_q, fl_d, fh_q, fh_d, fx_q, fx_d, lk_q, lk_d;
  ppp_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic do_ee, do_erase;
  logic [1:0] sel;
  assign sel = {bs2, bs1};

  always_comb begin
    cmd_d = cmd_q;
    alo_d = alo_q;
    ahi_d = ahi_q;
    dlo_d = dlo_q;
    dhi_d = dhi_q;
    fl_d = fl_q;
    fh_d = fh_q;
    fx_d = fx_q;
    lk_d = lk_q;
    pvalid_d = pvalid_q;
    st_d = st_q;
    cnt_d = cnt_q;
    do_ee = 1'b0;
    do_erase = 1'b0;
    // Loads are ignored while a write runs
    if (ld_rise && st_q == PPP_IDLE) begin
      case (act)
        PPP_ACT_CMD: begin
          cmd_d = din; // RULE1
          if (din == PPP_CMD_NOP) begin
            pvalid_d = '0; // RULE1
          end
        end
        PPP_ACT_ADDR: begin
          if (bs1) begin
            ahi_d = din; // RULE19
          end else begin
            alo_d = din; // RULE19
          end
        end
        PPP_ACT_DATA: begin
          if (bs1) begin
            dhi_d = din;
          end else begin
            dlo_d = din; // RULE19
          end
        end
        default: ; // RULE19
      endcase
    end
    if (pl_rise && st_q == PPP_IDLE && cmd_q == PPP_CMD_WR_EE) begin
      pvalid_d[alo_q[PW-1:0]] = 1'b1; // RULE2
    end
    case (st_q)
      PPP_IDLE: begin
        if (wr_fall) begin
          st_d = PPP_BUSY; // RULE4
          cnt_d = CW'(WRITE_CYC - 1);
          case (cmd_q)
            PPP_CMD_WR_EE: begin
              if (!bs1) begin
                do_ee = 1'b1; // RULE4
              end else begin
                st_d = PPP_IDLE;
              end
            end
            PPP_CMD_WR_FUSE: begin
              case (sel)
                2'b00: fl_d = dlo_q; // RULE9
                2'b01: fh_d = dlo_q; // RULE10
                2'b10: fx_d = dlo_q; // RULE11
                default: ;
              endcase
            end
            PPP_CMD_WR_LOCK: begin
              // Only clears bits; boot bits guarded in lock mode 3
              if (!lk_q[PPP_LOCK_GEN1_BIT] && !lk_q[PPP_LOCK_GEN2_BIT]) begin
                lk_d = lk_q & (dlo_q | PPP_BOOT_LOCK_MASK); // RULE14
              end else begin
                lk_d = lk_q & dlo_q; // RULE13 RULE15
              end
            end
            PPP_CMD_ERASE: do_erase = 1'b1;
            default: st_d = PPP_IDLE;
          endcase
        end
      end
      PPP_BUSY: begin
        if (cnt_q == '0) begin
          st_d = PPP_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: st_d = PPP_IDLE;
    endcase
    if (do_ee) begin
      pvalid_d = '0;
    end
    if (do_erase) begin
      lk_d = PPP_LOCK_RST; // RULE15
    end
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ld_q <= 1'b0;
      pl_q <= 1'b0;
      wr_q <= 1'b1;
      cmd_q <= PPP_CMD_NOP;
      alo_q <= 8'h00;
      ahi_q <= 8'h00;
      dlo_q <= PPP_ERASED;
      dhi_q <= PPP_ERASED;
      fl_q <= PPP_FUSE_RST;
      fh_q <= PPP_FUSE_RST;
      fx_q <= PPP_FUSE_RST;
      lk_q <= PPP_LOCK_RST;
      pvalid_q <= '0;
      st_q <= PPP_IDLE;
      cnt_q <= '0;
    end else if (en_i) begin
      ld_q <= ld;
      pl_q <= pl;
      wr_q <= wr_n;
      cmd_q <= cmd_d; // RULE21
      alo_q <= alo_d;
      ahi_q <= ahi_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      fl_q <= fl_d;
      fh_q <= fh_d;
      fx_q <= fx_d;
      lk_q <= lk_d;
      pvalid_q <= pvalid_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************
  // Memory arrays; no reset so they map onto RAM
  // ****************************************************
  logic [EW-1:0] ee_addr;
  assign ee_addr = EW'({ahi_q, alo_q});
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (pl_rise && st_q == PPP_IDLE && cmd_q == PPP_CMD_WR_EE) begin
        pbuf_q[alo_q[PW-1:0]] <= dlo_q; // RULE2
      end
      if (pl_rise && st_q == PPP_IDLE && cmd_q == PPP_CMD_WR_FLASH) begin
        flash_q[FW'({ahi_q, alo_q})] <= {dhi_q, dlo_q};
      end
      for (int i = 0; i < EE_PAGE; i++) begin
        // Whole page committed at once; unlatched bytes keep contents
        if (do_ee && pvalid_q[i]) begin
          ee_q[{ee_addr[EW-1:PW], PW'(i)}] <= pbuf_q[i]; // RULE2
        end
      end
      if (do_erase) begin
        for (int j = 0; j < FLASH_WORDS; j++) begin
          flash_q[j] <= {PPP_ERASED, PPP_ERASED};
        end
        for (int k = 0; k < EE_BYTES; k++) begin
          ee_q[k] <= PPP_ERASED;
        end
      end
    end
  end

  // ****************************************************
  // Read data select and bus drive
  // ****************************************************
  logic [7:0] rd;
  logic [15:0] fw;
  always_comb begin
    fw = flash_q[FW'({ahi_q, alo_q})];
    case (cmd_q)
      PPP_CMD_RD_FLASH: rd = bs1 ? fw[15:8] : fw[7:0]; // RULE6 RULE7
      PPP_CMD_RD_EE: rd = ee_q[ee_addr]; // RULE8
      PPP_CMD_RD_FUSE: begin
        case (sel)
          2'b00: rd = fl_q; // RULE16
          2'b11: rd = fh_q;
          2'b10: rd = fx_q;
          default: rd = lk_q;
        endcase
      end
      PPP_CMD_RD_SIG: begin
        if (bs1) begin
          rd = (alo_q == PPP_CAL_ADDR) ? CAL_BYTE : 8'h00; // RULE18
        end else begin
          case (alo_q)
            8'h00: rd = SIG0; // RULE17
            8'h01: rd = SIG1;
            PPP_SIG_LAST: rd = SIG2;
            default: rd = 8'h00;
          endcase
        end
      end
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      ready_busy_out_o <= 1'b1;
    end else if (en_i) begin
      data_o <= rd;
      data_oe_o <= ~oe_n; // RULE20
      ready_busy_out_o <= (st_d == PPP_IDLE); // RULE4
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  bus_drive_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE20
    en_i |=> data_oe_o == !$past(oe_n)) else $error("bus drive wrong");
  busy_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE4
    en_i && st_q == PPP_IDLE && wr_fall && cmd_q == PPP_CMD_WR_EE && !bs1
    |=> !ready_busy_out_o) else $error("no busy after write");
  nop_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE1
    en_i && ld_rise && st_q == PPP_IDLE && act == PPP_ACT_CMD
    && din == PPP_CMD_NOP |=> pvalid_q == '0) else $error("nop kept page");
  cmd_load_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE1
    en_i && ld_rise && st_q == PPP_IDLE && act == PPP_ACT_CMD
    |=> cmd_q == $past(din)) else $error("command not loaded");
  idle_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE19
    en_i && act == PPP_ACT_IDLE |=> $stable(cmd_q) && $stable(alo_q))
    else $error("idle action changed state");
  addr_load_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE19
    en_i && ld_rise && st_q == PPP_IDLE && act == PPP_ACT_ADDR && !bs1
    |=> alo_q == $past(din)) else $error("address low not loaded");
  lock_only_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE15
    en_i && !do_erase |=> ($past(lk_q) | lk_q) == $past(lk_q))
    else $error("lock bit released");
  boot_guard_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE14
    en_i && lk_q[1:0] == 2'b00 && !do_erase
    |=> (lk_q & PPP_BOOT_LOCK_MASK) == ($past(lk_q) & PPP_BOOT_LOCK_MASK))
    else $error("boot lock changed in mode 3");
  fuse_hi_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE10
    en_i && st_q == PPP_IDLE && wr_fall && cmd_q == PPP_CMD_WR_FUSE
    && sel == 2'b01 |=> fh_q == $past(dlo_q) ##1 1)
    else $error("fuse high not written");
  fuse_lo_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE9
    en_i && st_q == PPP_IDLE && wr_fall && cmd_q == PPP_CMD_WR_FUSE
    && sel == 2'b00 |=> fl_q == $past(dlo_q) && !ready_busy_out_o)
    else $error("fuse low not written");
  ee_write_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
    do_ee && en_i);
  fuse_read_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
    data_oe_o && cmd_q == PPP_CMD_RD_FUSE);
  busy_done_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
    !ready_busy_out_o ##1 ready_busy_out_o);
endmodule // ppp_port
`default_nettype wire

// [ppp_prog_model.sv]
// Behavioural model of the external parallel programmer
`timescale 1ns/100ps
`default_nettype none
module ppp_prog_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [7:0] bus_i,
  output logic load_o,
  output logic latch_o,
  output logic wr_n_o,
  output logic oe_n_o,
  output logic act_hi_o,
  output logic act_lo_o,
  output logic bs_lh_o,
  output logic bs_ext_o,
  output logic [7:0] data_o
);
  // ****************************************************
  // Idle pin levels
  // ****************************************************
  initial begin
    {load_o, latch_o, act_hi_o, act_lo_o, bs_lh_o, bs_ext_o} = 6'h00;
    wr_n_o = 1'b1;
    oe_n_o = 1'b1;
    data_o = 8'h00;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Four cycles per level, since pins pass a two-flop synchroniser
  task automatic load(input logic [1:0] act, input logic lh,
                      input logic [7:0] b);
    {act_hi_o, act_lo_o} = act;
    bs_lh_o = lh;
    data_o = b;
    wait_n(4);
    load_o = 1'b1;
    wait_n(4);
    load_o = 1'b0;
    wait_n(4);
  endtask
  // Page latch pulse, rising edge captures
  task automatic latch();
    latch_o = 1'b1;
    wait_n(4);
    latch_o = 1'b0;
    wait_n(4);
  endtask
  // Write pulse, then a bounded wait counting busy cycles
  task automatic write(input logic lh, input logic ext, output int busy);
    bs_lh_o = lh;
    bs_ext_o = ext;
    busy = 0;
    wait_n(4);
    wr_n_o = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (i == 3) wr_n_o = 1'b1;
      if (ready_i !== 1'b1) busy++;
      else if (busy > 0 && i > 3) break;
    end
    bs_lh_o = 1'b0;
    bs_ext_o = 1'b0;
    wait_n(4);
  endtask
  // Released bus shows the inverse so a stale value cannot pass
  task automatic read(input logic ext, input logic lh, output logic [7:0] v);
    bs_ext_o = ext;
    bs_lh_o = lh;
    data_o = ~data_o;
    oe_n_o = 1'b0;
    wait_n(6);
    v = bus_i;
    oe_n_o = 1'b1;
    wait_n(4);
  endtask
endmodule // ppp_prog_model
`default_nettype wire
